// >>> src/asf_top.sv
// Sample queue configuration, frame packing and serial register access.
// Overview of operation
// - Interrupt when enabled and trigger level reached.
// - Flush bit resets queue, stays until rewritten.
// - Layout 000 packs two single-channel samples.
// - Detach group uses active channel inputs.
// - Two-channel layout packs five flags, both results.
// - Select chooses which aux flags enter frames.
// - Trigger count equals field value plus one.
// - Configuration one write clears queue error, except while disabled with queue not empty.
// - Error when disabled with queue not empty.
// - Ready status follows trigger level comparison.
`timescale 1ns/10ps
module asf_top (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Serial register link from the host, asynchronous to clk.
  input  wire logic                         sclk,
  input  wire logic                         cs_n,
  input  wire logic                         mosi,
  output logic                              miso,
  output logic                              miso_oe,
  // Converter samples on clk.
  input  wire logic                         sample_valid,
  output logic                              sample_ready,
  input  wire logic [asf_pkg::ASF_RES_W-1:0] ch_one_result,
  input  wire logic [asf_pkg::ASF_RES_W-1:0] ch_two_result,
  input  wire logic                         ch_two_active,
  input  wire logic                         rld_stat,
  input  wire logic                         ch_one_pos_detach,
  input  wire logic                         ch_one_neg_detach,
  input  wire logic                         ch_two_pos_detach,
  input  wire logic                         ch_two_neg_detach,
  input  wire logic                         aux_pin_one,
  input  wire logic                         aux_pin_two,
  // Frame drain toward the read path.
  output logic                              frame_valid,
  input  wire logic                         frame_ready,
  output logic [asf_pkg::ASF_FRAME_W-1:0]   frame_data,
  // Status.
  output logic                              queue_irq,
  output logic                              queue_ready,
  output logic                              queue_error
);
  import asf_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]     sclk_s;  // Link clock synchroniser.
    logic [1:0]     cs_s;    // Select synchroniser.
    logic [1:0]     mosi_s;  // Data synchroniser.
    logic           sclk_p;  // Previous synchronised link clock.
    asf_phase_t     phase;   // Command or data byte.
    logic [2:0]     bitc;    // Bits of the current byte.
    logic [7:0]     rx;      // Incoming shift register.
    logic [6:0]     addr;    // Addressed register.
    logic           rd;      // Current command is a read.
    logic [7:0]     tx;      // Outgoing shift register.
    logic           miso;    // Driven data bit.
    logic [7:0]     cfg1;    // Queue configuration one.
    logic [7:0]     cfg2;    // Queue configuration two.
    logic           err;     // Sticky queue error.
    logic           half;    // First single-channel sample is held.
    logic [2:0]     h_det;   // Held detach group.
    logic           h_flag;  // Held aux flag.
    logic [23:0]    h_res;   // Held result.
  } asf_st_t;

  asf_st_t                  s_q;
  asf_st_t                  s_d;
  logic                     rise;
  logic                     fall;
  logic                     wr1;
  logic [7:0]               rbyte;
  logic                     push_valid;
  logic                     push_ready;
  logic [ASF_FRAME_W-1:0]   push_data;
  logic [2:0]               fcount;
  logic [2:0]               det3;
  logic                     flag1;
  logic [23:0]              act_res;
  logic                     ready_c;
  logic                     en;
  logic                     flush;
  logic [2:0]               lay;
  logic [2:0]               sel;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Register read mux; unmapped addresses read as zero.
  function automatic logic [7:0] asf_read(input logic [6:0] a, input logic [7:0] c1,
                                          input logic [7:0] c2, input logic [7:0] st);
    case (a)
      ASF_ADDR_CFG1: asf_read = c1;
      ASF_ADDR_CFG2: asf_read = c2;
      ASF_ADDR_STAT: asf_read = st;
      default:       asf_read = 8'h00;
    endcase
  endfunction : asf_read

  assign en    = s_q.cfg1[ASF_B_EN];
  assign flush = s_q.cfg1[ASF_B_FLUSH];
  assign lay   = s_q.cfg1[ASF_B_LAY_HI:ASF_B_LAY_LO];
  assign sel   = s_q.cfg2[ASF_B_SEL_HI:ASF_B_SEL_LO];
  assign rise  = s_q.sclk_s[1] && !s_q.sclk_p;
  assign fall  = !s_q.sclk_s[1] && s_q.sclk_p;

  // Ready when the held count exceeds the field, that is reaches field plus one.
  assign ready_c     = ({2'h0, fcount} > s_q.cfg2[ASF_B_TRIG_HI:0]);
  assign queue_ready = ready_c;
  assign queue_irq   = s_q.cfg1[ASF_B_INT_EN] && ready_c;
  assign queue_error = s_q.err;
  assign miso        = s_q.miso;
  assign miso_oe     = !s_q.cs_s[1] && (s_q.phase == ASF_DATA) && s_q.rd;
  // Status byte {ready, empty, full, error, level}; full is not shown while a flush holds the queue.
  assign rbyte       = {ready_c, (fcount == 3'h0), !sample_ready && !flush, s_q.err, 1'b0, fcount};

  // Detach group and flag of one single-channel sample.
  assign det3    = ch_two_active ? {rld_stat, ch_two_neg_detach, ch_two_pos_detach}
                                 : {rld_stat, ch_one_neg_detach, ch_one_pos_detach};
  assign act_res = ch_two_active ? ch_two_result : ch_one_result;
  assign flag1   = (sel[0] && aux_pin_one) || (sel[1] && aux_pin_two);
  assign sample_ready = push_ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Link decode, register writes, error flag and frame packing.
  always_comb begin
    logic [7:0] nb;
    nb         = {s_q.rx[6:0], s_q.mosi_s[1]};
    s_d        = s_q;
    wr1        = 1'b0;
    push_valid = 1'b0;
    push_data  = '0;
    s_d.sclk_s = {s_q.sclk_s[0], sclk};
    s_d.cs_s   = {s_q.cs_s[0], cs_n};
    s_d.mosi_s = {s_q.mosi_s[0], mosi};
    s_d.sclk_p = s_q.sclk_s[1];
    if (s_q.cs_s[1]) begin
      // Deselected: abandon any partial byte.
      s_d.phase = ASF_IDLE;
      s_d.bitc  = 3'h0;
    end else begin
      if (rise) begin
        s_d.rx   = nb;
        s_d.bitc = 3'(s_q.bitc + 1'b1);
        if (s_q.bitc == 3'h7) begin
          if (s_q.phase == ASF_DATA) begin
            s_d.phase = ASF_CMD;
            if (!s_q.rd && s_q.addr == ASF_ADDR_CFG1) begin
              s_d.cfg1 = nb;
              wr1      = 1'b1;
            end else if (!s_q.rd && s_q.addr == ASF_ADDR_CFG2) begin
              s_d.cfg2 = nb;
            end
          end else begin
            s_d.phase = ASF_DATA;
            s_d.rd    = nb[7];
            s_d.addr  = nb[6:0];
            // The address just received picks the byte, so a stale address never leaks into it.
            s_d.tx    = asf_read(nb[6:0], s_q.cfg1, s_q.cfg2, rbyte);
          end
        end else if (s_q.phase == ASF_IDLE) begin
          s_d.phase = ASF_CMD;
        end
      end
      if (fall && s_q.phase == ASF_DATA && s_q.rd) begin
        s_d.miso = s_q.tx[7];
        s_d.tx   = {s_q.tx[6:0], 1'b0};
      end
    end
    // Error sets while disabled with frames held; the set wins over the clear.
    if (!en && fcount != 3'h0) begin
      s_d.err = 1'b1;
    end else if (wr1) begin
      s_d.err = 1'b0;
    end
    // Frame packing; disabled or flushed queue takes nothing.
    if (!en || flush) begin
      s_d.half = 1'b0;
    end else if (sample_valid) begin
      case (lay)
        ASF_LAY_TWO: begin
          push_valid = 1'b1;
          push_data  = {rld_stat, ch_two_neg_detach, ch_two_pos_detach, ch_one_neg_detach,
                        ch_one_pos_detach, 1'b0, sel[1] && aux_pin_two, sel[0] && aux_pin_one,
                        ch_one_result, ch_two_result};
        end
        ASF_LAY_ONE: begin
          if (!s_q.half) begin
            s_d.half   = 1'b1;
            s_d.h_det  = det3;
            s_d.h_flag = flag1;
            s_d.h_res  = act_res;
          end else begin
            s_d.half   = 1'b0;
            push_valid = 1'b1;
            push_data  = {s_q.h_det, det3, s_q.h_flag, flag1, s_q.h_res, act_res};
          end
        end
        default: begin
          s_d.half = s_q.half;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.cs_s <= 2'h3;
      s_q.cfg1 <= ASF_CFG1_RST;
      s_q.cfg2 <= ASF_CFG2_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame queue
  // ---------------------------------------------------------------
  asf_fifo #(.W(ASF_FRAME_W), .D(ASF_DEPTH)) asf_fifo_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (frame_valid),
    .out_ready (frame_ready),
    .out_data  (frame_data),
    .count     (fcount)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_irq_off;
    @(posedge clk) disable iff (!rst_n) !s_q.cfg1[ASF_B_INT_EN] |-> !queue_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
  property p_irq_on;
    @(posedge clk) disable iff (!rst_n)
      s_q.cfg1[ASF_B_INT_EN] && ({2'h0, fcount} == 5'(s_q.cfg2[ASF_B_TRIG_HI:0] + 1'b1)) |-> queue_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("no interrupt at trigger level");
  property p_flush_holds;
    @(posedge clk) disable iff (!rst_n) flush && !wr1 |=> flush;
  endproperty
  a_flush_holds: assert property (p_flush_holds) else $error("flush cleared itself");
  property p_flush_empty;
    @(posedge clk) disable iff (!rst_n) flush |=> (fcount == 3'h0) && !frame_valid;
  endproperty
  a_flush_empty: assert property (p_flush_empty) else $error("queue not empty under flush");
  property p_disabled;
    @(posedge clk) disable iff (!rst_n) !en |-> !push_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("frame queued while disabled");
  property p_two_pack;
    @(posedge clk) disable iff (!rst_n)
      push_valid && lay == ASF_LAY_TWO |-> !push_data[50] && push_data[23:0] == ch_two_result
        && push_data[55] == rld_stat;
  endproperty
  a_two_pack: assert property (p_two_pack) else $error("two-channel frame misplaced");
  property p_one_pack;
    @(posedge clk) disable iff (!rst_n)
      push_valid && lay == ASF_LAY_ONE |-> push_data[23:0] == act_res && push_data[47:24] == s_q.h_res;
  endproperty
  a_one_pack: assert property (p_one_pack) else $error("single frame results wrong");
  property p_err_set;
    @(posedge clk) disable iff (!rst_n) !en && fcount != 3'h0 |=> s_q.err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("queue error not raised");
  property p_err_clr;
    @(posedge clk) disable iff (!rst_n) wr1 && !(!en && fcount != 3'h0) |=> !s_q.err;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("queue error not cleared");
  property p_no_flag;
    @(posedge clk) disable iff (!rst_n) push_valid && sel == 3'h0 |-> push_data[49:48] == 2'h0;
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("flag inserted with select zero");
endmodule : asf_top

// >>> src/asf_pkg.sv
// Package with register map, field positions, reset values and frame layout constants.
package asf_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [6:0] ASF_ADDR_CFG1  = 7'h16; // Queue configuration one.
  localparam logic [6:0] ASF_ADDR_CFG2  = 7'h17; // Queue configuration two.
  localparam logic [6:0] ASF_ADDR_STAT  = 7'h18; // Queue status, read only.
  localparam logic [7:0] ASF_CFG1_RST   = 8'h00; // Value of configuration one after reset.
  localparam logic [7:0] ASF_CFG2_RST   = 8'h00; // Value of configuration two after reset.
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ASF_B_INT_EN  = 7; // Threshold interrupt enable.
  localparam int ASF_B_FLUSH   = 4; // Software flush of the queue.
  localparam int ASF_B_LAY_HI  = 3; // Frame layout field, top bit.
  localparam int ASF_B_LAY_LO  = 1; // Frame layout field, bottom bit.
  localparam int ASF_B_EN      = 0; // Queue enable.
  localparam int ASF_B_SEL_HI  = 7; // Flag insert select, top bit.
  localparam int ASF_B_SEL_LO  = 5; // Flag insert select, bottom bit.
  localparam int ASF_B_TRIG_HI = 4; // Trigger level, top bit.
  // ---------------------------------------------------------------
  // Frame layouts and sizes
  // ---------------------------------------------------------------
  localparam logic [2:0] ASF_LAY_ONE = 3'h0; // Single channel, two samples a frame.
  localparam logic [2:0] ASF_LAY_TWO = 3'h1; // Two channels, one sample a frame.
  localparam int ASF_FRAME_W   = 56; // Bits in one frame.
  localparam int ASF_DEPTH     = 4;  // Frames the queue holds.
  localparam int ASF_RES_W     = 24; // Bits in one conversion result.
  // Serial link command states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    ASF_IDLE = 2'h0,
    ASF_CMD  = 2'h1,
    ASF_DATA = 2'h3
  } asf_phase_t;
endpackage : asf_pkg

// >>> src/asf_fifo.sv
// Parameterised frame queue with valid and ready on both sides.
`timescale 1ns/10ps
module asf_fifo #(
  parameter int W = 56,
  parameter int D = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // Fill level.
  output logic [$clog2(D+1)-1:0] count
);
  import asf_pkg::*;
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D+1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D); // Count when no slot is left.

  // All queue state in one word.
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Frame storage.
    logic [AW-1:0]       wp;    // Write pointer.
    logic [AW-1:0]       rp;    // Read pointer.
    logic [CW-1:0]       cnt;   // Frames held.
  } asf_fifo_st_t;

  asf_fifo_st_t s_q;
  asf_fifo_st_t s_d;
  logic         push;
  logic         pop;

  // Pointer advance with wrap, so a depth that is not a power of two works too.
  function automatic logic [AW-1:0] asf_inc(input logic [AW-1:0] p);
    asf_inc = (p == AW'(D-1)) ? '0 : AW'(p + 1'b1);
  endfunction : asf_inc

  // Flush holds the queue empty and refuses new frames while it lasts.
  assign in_ready  = (s_q.cnt != FULL_CNT) && !flush;
  assign out_valid = (s_q.cnt != '0) && !flush;
  assign out_data  = s_q.mem[s_q.rp];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state of pointers, storage and count.
  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wp] = in_data;
        s_d.wp          = asf_inc(s_q.wp);
      end
      if (pop) begin
        s_d.rp = asf_inc(s_q.rp);
      end
      if (push && !pop) begin
        s_d.cnt = CW'(s_q.cnt + 1'b1);
      end else if (pop && !push) begin
        s_d.cnt = CW'(s_q.cnt - 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : asf_fifo

// >>> bench/asf_host.sv
// Host model that drives the serial register link in mode 0.
`timescale 1ns/10ps
module asf_host (
  // System clock, used to place the start of a frame and the gap after it.
  input  wire logic clk,
  // Serial link.
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  // The link clock stands still low between frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  // Command byte then data byte, MSB first, 800 ns a bit.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge clk);
    // Odd offset keeps the link edges out of phase with the clock.
    #37;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = sh[i];
      #400;
      sclk = 1'b1;
      // An undriven line reads as unknown, so a missing enable never matches.
      if (i < 8) begin
        rd = {rd[6:0], miso_oe ? miso : 1'bx};
      end
      #400;
      sclk = 1'b0;
    end
    #400;
    cs_n = 1'b1;
    // A released line shows the inverse of its last value.
    mosi = ~mosi;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : asf_host

// >>> bench/asf_top_tb.sv
// Self-checking testbench for the sample queue block.
`timescale 1ns/10ps
module asf_top_tb;
  import asf_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk, rst_n, sclk, cs_n, mosi, miso, miso_oe;
  logic sample_valid, sample_ready, ch_two_active, rld_stat;
  logic aux_pin_one, aux_pin_two, frame_valid, frame_ready;
  logic queue_irq, queue_ready, queue_error;
  logic [3:0] det;                     // Detach flags {c2n, c2p, c1n, c1p}.
  logic [ASF_RES_W-1:0] r1, r2;        // Conversion results.
  logic [ASF_FRAME_W-1:0] frame_data;  // Head frame.
  logic [ASF_FRAME_W-1:0] exp_q[$];    // Frames expected in order.
  logic [7:0] rd;                      // Last read value.
  int error_cnt, cmp_count, cyc;       // Counters.
  asf_top asf_top_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .sample_valid(sample_valid), .sample_ready(sample_ready), .ch_one_result(r1),
    .ch_two_result(r2), .ch_two_active(ch_two_active), .rld_stat(rld_stat), .ch_one_pos_detach(det[0]),
    .ch_one_neg_detach(det[1]), .ch_two_pos_detach(det[2]), .ch_two_neg_detach(det[3]),
    .aux_pin_one(aux_pin_one), .aux_pin_two(aux_pin_two), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_data(frame_data), .queue_irq(queue_irq),
    .queue_ready(queue_ready), .queue_error(queue_error));
  asf_host asf_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Register write and checked read over the serial link.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    asf_host_inst.xfer({1'b0, a}, d, rd);
  endtask : wr
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    asf_host_inst.xfer({1'b1, a}, 8'h00, rd);
    chk("register", {48'h0, e}, {48'h0, rd});
  endtask : rchk
  // Status flags {frame_valid, sample_ready, queue_ready, queue_irq, queue_error}.
  task automatic fl(input logic [4:0] e);
    @(negedge clk);
    chk("flags", {51'h0, e}, {51'h0, frame_valid, sample_ready, queue_ready, queue_irq, queue_error});
  endtask : fl
  // One converter sample; f is {rld, c2n, c2p, c1n, c1p}, ax is {aux two, aux one}.
  task automatic push(input logic [23:0] a, input logic [23:0] b, input logic act, input logic [4:0] f,
                      input logic [1:0] ax);
    @(negedge clk);
    r1 = a;
    r2 = b;
    ch_two_active = act;
    {rld_stat, det} = f;
    {aux_pin_two, aux_pin_one} = ax;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask : push
  // Waits for a frame under a bound, checks it and pops it.
  task automatic pop(input logic [55:0] e);
    int n;
    n = 0;
    while (frame_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("frame_data", e, frame_data);
    frame_ready = 1'b1;
    @(negedge clk);
    frame_ready = 1'b0;
  endtask : pop
  // Expected two-channel frame.
  function automatic logic [55:0] two_ch(logic [4:0] f, logic [1:0] ax, logic [2:0] s, logic [23:0] a, b);
    return {f, 1'b0, ax[1] & s[1], ax[0] & s[0], a, b};
  endfunction : two_ch
  // Detach group and flag of one single-channel sample.
  function automatic logic [3:0] one_s(logic [4:0] f, logic act, logic [1:0] ax, logic [2:0] s);
    return {f[4], act ? f[3:2] : f[1:0], (ax[0] & s[0]) | (ax[1] & s[1])};
  endfunction : one_s
  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The tests need about 3300 cycles; well past that counts as a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] s1, s2;
    rst_n = 1'b0; sample_valid = 1'b0; frame_ready = 1'b0; r1 = '0; r2 = '0;
    ch_two_active = 1'b0; rld_stat = 1'b0; det = 4'h0; aux_pin_one = 1'b0; aux_pin_two = 1'b0;
    error_cnt = 0; cmp_count = 0; cyc = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Reset values, unmapped place, disabled queue.
    rchk(ASF_ADDR_CFG1, ASF_CFG1_RST);
    rchk(ASF_ADDR_CFG2, ASF_CFG2_RST);
    rchk(ASF_ADDR_STAT, 8'h40);
    wr(7'h21, 8'hff);
    rchk(7'h21, 8'h00);
    rchk(ASF_ADDR_CFG1, 8'h00);
    push(24'h123456, 24'h654321, 1'b0, 5'h1f, 2'b11);
    fl(5'b01000);
    // Two-channel layout with flag select codes 0 to 3.
    wr(ASF_ADDR_CFG1, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wr(ASF_ADDR_CFG2, {s[2:0], 5'h03});
      push({20'h10000, s[3:0]}, {20'ha0000, s[3:0]}, 1'b0, 5'b10110, 2'b11);
      pop(two_ch(5'b10110, 2'b11, s[2:0], {20'h10000, s[3:0]}, {20'ha0000, s[3:0]}));
    end
    // Trigger of four items, fill to full, interrupt, drop, drain.
    for (int k = 0; k < 4; k++) begin
      fl({k != 0, 4'b1000});
      push({20'h30000, k[3:0]}, {20'h40000, k[3:0]}, 1'b1, {k[4:0] ^ 5'h15}, k[1:0]);
      exp_q.push_back(two_ch(k[4:0] ^ 5'h15, k[1:0], 3'h3, {20'h30000, k[3:0]}, {20'h40000, k[3:0]}));
      if (k < 3) fl(5'b11000);
    end
    fl(5'b10100);
    rchk(ASF_ADDR_STAT, 8'ha4);
    wr(ASF_ADDR_CFG1, 8'h83);
    fl(5'b10110);
    push(24'hdead00, 24'hbeef00, 1'b0, 5'h00, 2'b00);
    while (exp_q.size() > 0) pop(exp_q.pop_front());
    fl(5'b01000);
    wr(ASF_ADDR_CFG2, 8'h60);
    push(24'h000001, 24'h000002, 1'b0, 5'h01, 2'b01);
    fl(5'b11110);
    pop(two_ch(5'h01, 2'b01, 3'h3, 24'h000001, 24'h000002));
    // Single-channel layout, channel one then channel two active.
    wr(ASF_ADDR_CFG1, 8'h01);
    wr(ASF_ADDR_CFG2, 8'h20);
    push(24'h5a5a5a, 24'h5a5a5a, 1'b0, 5'b10110, 2'b01);
    fl(5'b01000);
    push(24'hc3c3c3, 24'hc3c3c3, 1'b1, 5'b01101, 2'b10);
    s1 = one_s(5'b10110, 1'b0, 2'b01, 3'h1);
    s2 = one_s(5'b01101, 1'b1, 2'b10, 3'h1);
    pop({s1[3:1], s2[3:1], s1[0], s2[0], 24'h5a5a5a, 24'hc3c3c3});
    // Flush holds until written back to zero.
    push(24'h000011, 24'h000011, 1'b0, 5'h00, 2'b00);
    push(24'h000022, 24'h000022, 1'b0, 5'h00, 2'b00);
    wr(ASF_ADDR_CFG1, 8'h11);
    fl(5'b00000);
    rchk(ASF_ADDR_CFG1, 8'h11);
    push(24'h000033, 24'h000033, 1'b0, 5'h00, 2'b00);
    fl(5'b00000);
    wr(ASF_ADDR_CFG1, 8'h01);
    fl(5'b01000);
    // Disable with a frame stored, then clear the error.
    push(24'h000044, 24'h000044, 1'b0, 5'h00, 2'b00);
    push(24'h000055, 24'h000055, 1'b0, 5'h00, 2'b00);
    wr(ASF_ADDR_CFG1, 8'h00);
    fl(5'b11101);
    rchk(ASF_ADDR_STAT, 8'h91);
    wr(ASF_ADDR_CFG1, 8'h10);
    wr(ASF_ADDR_CFG1, 8'h00);
    fl(5'b01000);
    wrap_up();
  end
endmodule : asf_top_tb
